// ==== rtl/bcs_top.sv ====
// Board control: reset hold, default loading, pixel divider, remote
// inputs and steering of the host three-wire stream to one target.
// Assumes a 10 MHz clock and a host serial clock well below clk/4.
`timescale 1ns/10ps
module bcs_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_pwr_good_dly,
	input wire logic [15:0] i_remote_control_inputs,
	input wire logic i_serial_bit_clock,
	input wire logic i_serial_bit_line,
	input wire logic i_host_load_strobe_n,
	input wire logic i_integrate,
	output logic o_pixel_clk,
	output logic [15:0] o_remote_control_mode,
	output logic o_tg_target_load_strobe_n,
	output logic o_afe1_target_load_strobe_n,
	output logic o_afe2_target_load_strobe_n,
	output logic o_dev_serial_bit_clock,
	output logic o_dev_serial_bit_line,
	output logic [15:0] o_self_config,
	output logic o_init_done,
	output logic o_tg_reset_n,
	output logic o_exposure_window
);
	bcs_ser_if ser ();
	bcs_pkg::bcs_state_e state_r;

	// Pin synchronisers; stage one feeds stage two only
	logic [20:0] pin_s1, pin_s2;
	logic sclk_s3;
	logic pg_s, sclk_s, sdat_s, hl_n_s, integ_s, h_rise;
	logic [15:0] rc_s;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_s1 <= 21'h0;
			pin_s2 <= 21'h0;
		end else begin
			pin_s1 <= {i_pwr_good_dly, i_serial_bit_clock, i_serial_bit_line,
				i_host_load_strobe_n, i_integrate, i_remote_control_inputs};
			pin_s2 <= pin_s1;
		end
	end

	assign pg_s = pin_s2[20];
	assign sclk_s = pin_s2[19];
	assign sdat_s = pin_s2[18];
	assign hl_n_s = pin_s2[17];
	assign integ_s = pin_s2[16];
	assign rc_s = pin_s2[15:0];

	// Edge detect on the settled copy only
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			sclk_s3 <= 1'b0;
		else
			sclk_s3 <= sclk_s;
	end

	assign h_rise = sclk_s & ~sclk_s3;

	// Init sequencer bookkeeping
	logic [2:0] idx_r;
	logic wait_r, start_r, init_fin;
	logic [1:0] bitcnt_r;
	logic [2:0] sel_r;
	logic tx_rst_r;

	assign init_fin = (state_r == bcs_pkg::ST_INIT) && !wait_r &&
		(idx_r == bcs_pkg::INIT_N);

	// Main state: power-good low always wins, e.g. the reset button
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= bcs_pkg::ST_HOLD;
		end else if (!pg_s) begin
			state_r <= bcs_pkg::ST_HOLD;
		end else begin
			unique case (state_r)
				bcs_pkg::ST_HOLD:
					state_r <= bcs_pkg::ST_INIT;
				bcs_pkg::ST_INIT:
					if (init_fin)
						state_r <= bcs_pkg::ST_IDLE;
				bcs_pkg::ST_IDLE:
					if (!hl_n_s && h_rise && bitcnt_r == 2'h2)
						state_r <= bcs_pkg::ST_PASS;
				bcs_pkg::ST_PASS:
					if (hl_n_s)
						state_r <= bcs_pkg::ST_IDLE;
			endcase
		end
	end

	// Default writes issued one after another through the serializer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			idx_r <= 3'h0;
			wait_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			if (state_r != bcs_pkg::ST_INIT) begin
				idx_r <= 3'h0;
				wait_r <= 1'b0;
			end else if (wait_r) begin
				if (ser.done) begin
					wait_r <= 1'b0;
					idx_r <= idx_r + 3'h1;
				end
			end else if (idx_r != bcs_pkg::INIT_N && !ser.busy) begin
				start_r <= 1'b1;
				wait_r <= 1'b1;
			end
		end
	end

	// Frame word: direction low, address, data, all LSB first
	assign ser.start = start_r;
	assign ser.sel = bcs_pkg::INIT_SEL[idx_r[1:0]];
	assign ser.len = bcs_pkg::INIT_LEN[idx_r[1:0]];
	assign ser.word = {11'h0, bcs_pkg::INIT_DATA[idx_r[1:0]],
		bcs_pkg::INIT_ADDR[idx_r[1:0]], 1'b0};

	// Serializer held in reset through hold, so a write cut by the
	// reset button never runs on into the next default sequence
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			tx_rst_r <= 1'b1;
		else
			tx_rst_r <= (state_r == bcs_pkg::ST_HOLD);
	end

	bcs_ser_tx bcs_ser_tx_inst (
		.i_clk(i_clk),
		.i_rst(tx_rst_r),
		.s(ser)
	);

	// Select field collection, MSB first
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bitcnt_r <= 2'h0;
			sel_r <= 3'h0;
		end else if (state_r == bcs_pkg::ST_IDLE) begin
			if (hl_n_s)
				bitcnt_r <= 2'h0;
			else if (h_rise) begin
				sel_r <= {sel_r[1:0], sdat_s};
				bitcnt_r <= (bitcnt_r == 2'h2) ? 2'h0 : bitcnt_r + 2'h1;
			end
		end
	end

	// Stream aimed at this device lands in a local word
	logic [15:0] self_sh_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			self_sh_r <= bcs_pkg::SELF_CFG_RST;
			o_self_config <= bcs_pkg::SELF_CFG_RST;
		end else if (state_r == bcs_pkg::ST_PASS &&
				sel_r == bcs_pkg::SEL_SELF) begin
			if (hl_n_s)
				o_self_config <= self_sh_r;
			else if (h_rise)
				self_sh_r <= {sdat_s, self_sh_r[15:1]};
		end
	end

	// Steering: no checks on the bits, only the target is chosen
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{o_afe2_target_load_strobe_n, o_afe1_target_load_strobe_n,
				o_tg_target_load_strobe_n} <= bcs_pkg::STROBES_IDLE;
			o_dev_serial_bit_clock <= 1'b0;
			o_dev_serial_bit_line <= 1'b0;
		end else if (state_r == bcs_pkg::ST_INIT) begin
			{o_afe2_target_load_strobe_n, o_afe1_target_load_strobe_n,
				o_tg_target_load_strobe_n} <= ser.load_n;
			o_dev_serial_bit_clock <= ser.sclk;
			o_dev_serial_bit_line <= ser.serial_bit_line;
		end else if (state_r == bcs_pkg::ST_PASS && !hl_n_s) begin
			{o_afe2_target_load_strobe_n, o_afe1_target_load_strobe_n,
				o_tg_target_load_strobe_n} <= bcs_pkg::strobe_of(sel_r);
			// High only from a fresh rise: the third select pulse is
			// still high on entry and must not reach the target
			o_dev_serial_bit_clock <= h_rise |
				(sclk_s & o_dev_serial_bit_clock);
			o_dev_serial_bit_line <= sdat_s;
		end else begin
			{o_afe2_target_load_strobe_n, o_afe1_target_load_strobe_n,
				o_tg_target_load_strobe_n} <= bcs_pkg::STROBES_IDLE;
			o_dev_serial_bit_clock <= 1'b0;
			o_dev_serial_bit_line <= 1'b0;
		end
	end

	// Pixel divider stops in hold so the imager sees no stray edges
	logic [7:0] pix_cnt_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pix_cnt_r <= 8'h0;
			o_pixel_clk <= 1'b0;
		end else if (state_r == bcs_pkg::ST_HOLD) begin
			pix_cnt_r <= 8'h0;
			o_pixel_clk <= 1'b0;
		end else if (pix_cnt_r == 8'(bcs_pkg::PIX_HALF - 1)) begin
			pix_cnt_r <= 8'h0;
			o_pixel_clk <= ~o_pixel_clk;
		end else begin
			pix_cnt_r <= pix_cnt_r + 8'h1;
		end
	end

	// Plain outputs; remote lines rely on board pull-downs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_remote_control_mode <= 16'h0000;
			o_exposure_window <= 1'b0;
			o_init_done <= 1'b0;
			o_tg_reset_n <= 1'b0;
		end else begin
			o_remote_control_mode <= pg_s ? rc_s : 16'h0000;
			o_exposure_window <= integ_s;
			o_init_done <= (state_r == bcs_pkg::ST_IDLE) ||
				(state_r == bcs_pkg::ST_PASS);
			o_tg_reset_n <= (state_r != bcs_pkg::ST_HOLD);
		end
	end

	a_hold_no_strobe: assert property (@(posedge i_clk) disable iff (i_rst)
		(!pg_s) |=> ##1 (o_tg_target_load_strobe_n &&
		o_afe1_target_load_strobe_n && o_afe2_target_load_strobe_n &&
		!o_tg_reset_n))
		else $error("strobe or reset active while power-good low");

	a_init_starts: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_r == bcs_pkg::ST_HOLD && pg_s) |=> ##1 start_r)
		else $error("init did not start after power-good");

	a_pixel_half: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_r != bcs_pkg::ST_HOLD && $past(state_r) != bcs_pkg::ST_HOLD &&
		$rose(o_pixel_clk)) |=> !o_pixel_clk)
		else $error("pixel clock above half the system clock");

	a_remote_follow: assert property (@(posedge i_clk) disable iff (i_rst)
		(pg_s && rc_s == 16'h0000) |=> (o_remote_control_mode == 16'h0000))
		else $error("remote mode not zero with idle lines");

	a_init_completes: assert property (@(posedge i_clk) disable iff (i_rst)
		($rose(state_r == bcs_pkg::ST_INIT)) |->
		##[1:600] (state_r != bcs_pkg::ST_INIT))
		else $error("default loading did not finish");

	a_select_msb: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_r == bcs_pkg::ST_IDLE && pg_s && !hl_n_s && h_rise &&
		bitcnt_r == 2'h2) |=> (state_r == bcs_pkg::ST_PASS &&
		sel_r == {$past(sel_r[1:0]), $past(sdat_s)}))
		else $error("select field not taken MSB first");

	a_exposure_track: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 (o_exposure_window == $past(integ_s)))
		else $error("exposure window not tracking integration");

	a_route_target: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_r == bcs_pkg::ST_PASS && pg_s && !hl_n_s) |=>
		({o_afe2_target_load_strobe_n, o_afe1_target_load_strobe_n,
		o_tg_target_load_strobe_n} == bcs_pkg::strobe_of($past(sel_r))))
		else $error("wrong target strobe during pass-through");

	a_pass_data: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_r == bcs_pkg::ST_PASS && pg_s && !hl_n_s) |=>
		(o_dev_serial_bit_line == $past(sdat_s) &&
		(!o_dev_serial_bit_clock || $past(sclk_s)) &&
		(!$past(h_rise) || o_dev_serial_bit_clock)))
		else $error("stream not passed through");

	a_pass_no_stray: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(state_r == bcs_pkg::ST_PASS) |=> !o_dev_serial_bit_clock)
		else $error("select clock pulse leaked to target");

	a_frame_release: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_r == bcs_pkg::ST_PASS && hl_n_s) |=>
		(o_tg_target_load_strobe_n && o_afe1_target_load_strobe_n &&
		o_afe2_target_load_strobe_n) ##1 (state_r != bcs_pkg::ST_PASS))
		else $error("strobes not released at frame end");

endmodule // bcs_top

// ==== inc/bcs_pkg.sv ====
// Constants, state codes and the power-up defaults for board control
// and serial steering. Assumes one system clock and the host framing.
// Overview of operation
// - Hold the control logic in reset until the delayed power-good input is high.
// - When power-good rises, start the power-up initialization sequence.
// - Derive pixel timing by dividing the system clock, never above half of it.
// - Unconnected remote control inputs read as zero.
// - Default mode works with no remote control inputs supplied at all.
// - Decode serial streams so each timing device can be reconfigured alone.
// - Run on stored defaults if the host never uses the serial path.
// - Initialization loads defaults into the timing generator and both front ends.
// - The first three serial bits are the target-select field, MSB first.
// - The exposure-window output is high exactly during integration; the code has it follow the integrate input three clocks late.
// - Select 000 is this device, 001 front end 1, 010 front end 2, 011 timing generator, 1xx reserved.
// - After decoding, drop that target's load strobe and pass bits through unchecked.
package bcs_pkg;

	// Target-select codes
	localparam logic [2:0] SEL_SELF = 3'h0;
	localparam logic [2:0] SEL_AFE1 = 3'h1;
	localparam logic [2:0] SEL_AFE2 = 3'h2;
	localparam logic [2:0] SEL_TG = 3'h3;

	// Clock and derived timing
	localparam int CLK_MHZ = 10;
	localparam int PIX_DIV = 2; // Divide ratio, two is the fastest legal
	localparam int PIX_HALF = PIX_DIV / 2;
	localparam int SER_HALF_NS = 200;
	localparam int SER_HALF_CYC = (SER_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int POWER_DELAY_MS = 400; // Made by the external RC network

	// Frame layout of a default write: direction, address, data
	localparam int WORD_W = 32;
	localparam int LEN_W = 6;
	localparam int ADDR_W = 4;
	localparam logic [LEN_W-1:0] TG_FRAME_LEN = 6'h15; // 1 + 4 + 16
	localparam logic [LEN_W-1:0] AFE_FRAME_LEN = 6'h11; // 1 + 4 + 12

	// Default table, one entry per register write
	localparam logic [2:0] INIT_N = 3'h4;
	localparam logic [2:0] INIT_SEL [4] = '{SEL_TG, SEL_TG, SEL_AFE1, SEL_AFE2};
	localparam logic [ADDR_W-1:0] INIT_ADDR [4] = '{4'h1, 4'h2, 4'h0, 4'h0};
	localparam logic [15:0] INIT_DATA [4] = '{16'h0001, 16'h0000, 16'h0000,
		16'h0000};
	localparam logic [LEN_W-1:0] INIT_LEN [4] = '{TG_FRAME_LEN, TG_FRAME_LEN,
		AFE_FRAME_LEN, AFE_FRAME_LEN};

	// Reset values
	localparam logic [2:0] STROBES_IDLE = 3'h7;
	localparam logic [15:0] SELF_CFG_RST = 16'h0000;

	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_INIT = 4'h2,
		ST_IDLE = 4'h4,
		ST_PASS = 4'h8
	} bcs_state_e;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h1,
		TX_LOW = 3'h2,
		TX_HIGH = 3'h4
	} bcs_tx_e;

	// Active-low strobes {afe2, afe1, tg}; self and reserved drive none
	function automatic logic [2:0] strobe_of(input logic [2:0] sel);
		logic [2:0] s;
		s = STROBES_IDLE;
		if (sel == SEL_TG)
			s[0] = 1'b0;
		else if (sel == SEL_AFE1)
			s[1] = 1'b0;
		else if (sel == SEL_AFE2)
			s[2] = 1'b0;
		return s;
	endfunction

endpackage

// ==== inc/bcs_ser_if.sv ====
// Request and pin signals between the init sequencer and the serializer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface bcs_ser_if;
	logic start;
	logic [2:0] sel;
	logic [5:0] len;
	logic [31:0] word;
	logic busy;
	logic done;
	logic [2:0] load_n;
	logic sclk;
	logic serial_bit_line;
	modport tx (input start, sel, len, word,
		output busy, done, load_n, sclk, serial_bit_line);
	modport ctl (output start, sel, len, word,
		input busy, done, load_n, sclk, serial_bit_line);
endinterface

// ==== rtl/bcs_ser_tx.sv ====
// Three-wire serializer for default writes, LSB of word first.
// Assumes start only while not busy; one clock, async reset.
`timescale 1ns/10ps
module bcs_ser_tx (
	input wire logic i_clk,
	input wire logic i_rst,
	bcs_ser_if.tx s
);
	bcs_pkg::bcs_tx_e st_r;
	logic [31:0] sh_r;
	logic [5:0] left_r;
	logic [3:0] cnt_r;
	logic half_end;

	assign half_end = (cnt_r == 4'(bcs_pkg::SER_HALF_CYC - 1));

	// Bit engine: data set while clock low, target samples on the rise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= bcs_pkg::TX_IDLE;
			sh_r <= 32'h0;
			left_r <= 6'h0;
			cnt_r <= 4'h0;
			s.load_n <= bcs_pkg::STROBES_IDLE;
			s.sclk <= 1'b0;
			s.serial_bit_line <= 1'b0;
			s.done <= 1'b0;
		end else begin
			s.done <= 1'b0;
			unique case (st_r)
				bcs_pkg::TX_IDLE: begin
					if (s.start) begin
						sh_r <= s.word;
						left_r <= s.len;
						cnt_r <= 4'h0;
						s.load_n <= bcs_pkg::strobe_of(s.sel);
						st_r <= bcs_pkg::TX_LOW;
					end
				end
				bcs_pkg::TX_LOW: begin
					s.sclk <= 1'b0;
					s.serial_bit_line <= sh_r[0];
					cnt_r <= half_end ? 4'h0 : cnt_r + 4'h1;
					if (half_end)
						st_r <= bcs_pkg::TX_HIGH;
				end
				bcs_pkg::TX_HIGH: begin
					s.sclk <= 1'b1;
					cnt_r <= half_end ? 4'h0 : cnt_r + 4'h1;
					if (half_end) begin
						sh_r <= {1'b0, sh_r[31:1]};
						left_r <= left_r - 6'h1;
						if (left_r == 6'h1) begin
							s.load_n <= bcs_pkg::STROBES_IDLE;
							s.done <= 1'b1;
							st_r <= bcs_pkg::TX_IDLE;
						end else begin
							st_r <= bcs_pkg::TX_LOW;
						end
					end
				end
			endcase
		end
	end

	assign s.busy = (st_r != bcs_pkg::TX_IDLE);

	a_tx_clock_framed: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(s.sclk) |-> (s.load_n != bcs_pkg::STROBES_IDLE))
		else $error("serial clock rose with no strobe low");

endmodule // bcs_ser_tx

// ==== sim/bcs_host.sv ====
// Host model: drives three-wire write frames into the board.
// Assumes the bench clock; pins change on falling edges only.
`timescale 1ns/10ps
module bcs_host (
	input wire logic i_clk,
	output logic o_sclk,
	output logic o_serial_bit_line,
	output logic o_load_n
);
	// Idle: serial clock stands still, frame strobe high
	initial begin
		o_sclk = 1'b0;
		o_serial_bit_line = 1'b0;
		o_load_n = 1'b1;
	end

	// Four clocks a half period, so the serial clock is clk/8, well below clk/4
	task automatic half();
		repeat (4) @(negedge i_clk);
	endtask

	// Select MSB first, direction low, address and data LSB first
	task automatic send(input logic [2:0] sel, input logic [3:0] addr,
		input logic [15:0] data);
		logic [23:0] bits;
		bits = {data, addr, 1'b0, sel[0], sel[1], sel[2]};
		@(negedge i_clk);
		o_load_n = 1'b0;
		half();
		for (int i = 0; i < 24; i++) begin
			o_serial_bit_line = bits[i];
			half();
			o_sclk = 1'b1;
			half();
			o_sclk = 1'b0;
		end
		half();
		o_load_n = 1'b1;
		o_serial_bit_line = ~o_serial_bit_line; // Released line must not keep its last level
		repeat (12) @(negedge i_clk);
	endtask
endmodule // bcs_host

// ==== sim/tb_board_control_serial_steering.sv ====
// Bench for board control: power-up hold, default loading, steering of
// host frames, remote lines, pixel clock and exposure window.
// Assumes bcs_pkg and the host model; inputs move on falling edges.
`timescale 1ns/10ps
module tb_board_control_serial_steering;
	logic i_clk, i_rst, i_pwr_good_dly, sclk, serial_bit_line, load_n;
	logic i_integrate = 1'b0;
	logic [15:0] i_remote_control_inputs, o_remote_control_mode;
	logic [15:0] o_self_config;
	logic o_pixel_clk, tg_n, afe1_n, afe2_n, o_dclk, o_dline;
	logic o_init_done, o_tg_reset_n, o_exposure_window, p;
	logic [40:0] notes [$];
	logic [40:0] got = '0;
	logic [31:0] seed = 32'h46;
	logic [31:0] r;
	logic [2:0] strb_tab [4] = '{3'h7, 3'h5, 3'h3, 3'h6};
	logic [3:0] hist = 4'h0;
	logic dclk_q = 1'b0;
	logic act = 1'b0;
	logic skip = 1'b0;
	logic run_int = 1'b0;
	int errors = 0;
	int check_count = 0;
	int nbits = 0;

	bcs_top bcs_top_inst (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pwr_good_dly(i_pwr_good_dly),
		.i_remote_control_inputs(i_remote_control_inputs),
		.i_serial_bit_clock(sclk),
		.i_serial_bit_line(serial_bit_line),
		.i_host_load_strobe_n(load_n),
		.i_integrate(i_integrate),
		.o_pixel_clk(o_pixel_clk),
		.o_remote_control_mode(o_remote_control_mode),
		.o_tg_target_load_strobe_n(tg_n),
		.o_afe1_target_load_strobe_n(afe1_n),
		.o_afe2_target_load_strobe_n(afe2_n),
		.o_dev_serial_bit_clock(o_dclk),
		.o_dev_serial_bit_line(o_dline),
		.o_self_config(o_self_config),
		.o_init_done(o_init_done),
		.o_tg_reset_n(o_tg_reset_n),
		.o_exposure_window(o_exposure_window)
	);

	bcs_host bcs_host_inst (
		.i_clk(i_clk),
		.o_sclk(sclk),
		.o_serial_bit_line(serial_bit_line),
		.o_load_n(load_n)
	);

	// 10 MHz system clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string name, input logic [40:0] seen,
		input logic [40:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Notes for the four default writes, masked to the bits really sent
	task automatic init_notes();
		logic [31:0] w;
		for (int k = 0; k < 4; k++) begin
			w = {11'h0, bcs_pkg::INIT_DATA[k], bcs_pkg::INIT_ADDR[k], 1'b0};
			w &= (32'h1 << bcs_pkg::INIT_LEN[k]) - 32'h1;
			notes.push_back({strb_tab[bcs_pkg::INIT_SEL[k][1:0]],
				bcs_pkg::INIT_LEN[k], w});
		end
	endtask

	// Gather forwarded bits; a frame closes when every strobe is high
	always @(negedge i_clk) begin
		if ({afe2_n, afe1_n, tg_n} !== 3'h7) begin
			got[40:38] = {afe2_n, afe1_n, tg_n};
			if (o_dclk === 1'b1 && dclk_q === 1'b0 && nbits < 32) begin
				got[nbits] = o_dline;
				nbits++;
			end
			act = 1'b1;
		end else if (act) begin
			got[37:32] = nbits[5:0];
			if (!skip && notes.size() == 0) begin
				errors++;
				$display("wrong value frame expected none seen %h", got);
			end else if (!skip)
				check("frame", got, notes.pop_front());
			act = 1'b0;
			nbits = 0;
			got = '0;
		end
		dclk_q = o_dclk;
	end

	// Random integrate level; window must follow three clocks later
	always @(negedge i_clk) begin
		if (run_int) begin
			check("exposure", o_exposure_window, hist[2]);
			r = rnd();
			hist <= {hist[2:0], r[7]};
			i_integrate <= r[7];
		end
	end

	initial begin
		i_rst = 1'b1;
		i_pwr_good_dly = 1'b0;
		i_remote_control_inputs = 16'h0;
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (20) @(negedge i_clk);
		check("hold", {o_init_done, o_tg_reset_n, o_pixel_clk}, 41'h0);
		// Board reset pressed while the first default write runs
		skip = 1'b1;
		i_pwr_good_dly = 1'b1;
		repeat (30) @(negedge i_clk);
		i_pwr_good_dly = 1'b0;
		repeat (8) @(negedge i_clk);
		check("abort", {o_init_done, o_tg_reset_n, afe2_n, afe1_n, tg_n},
			41'h7);
		skip = 1'b0;
		init_notes();
		i_pwr_good_dly = 1'b1;
		for (int n = 0; n < 800 && o_init_done !== 1'b1; n++)
			@(negedge i_clk);
		repeat (4) @(negedge i_clk);
		check("init", {o_init_done, o_tg_reset_n}, 41'h3);
		check("init left", notes.size(), 41'h0);
		check("remote idle", o_remote_control_mode, 41'h0);
		check("self", o_self_config, bcs_pkg::SELF_CFG_RST);
		for (int i = 0; i < 16; i++) begin
			p = o_pixel_clk;
			@(negedge i_clk);
			check("pixel", o_pixel_clk, !p);
		end
		repeat (4) begin
			r = rnd();
			i_remote_control_inputs = r[15:0];
			repeat (4) @(negedge i_clk);
			check("remote", o_remote_control_mode, r[15:0]);
		end
		run_int = 1'b1;
		repeat (64) @(negedge i_clk);
		run_int = 1'b0;
		// Every select code; reserved ones must leave all strobes high
		for (int s = 0; s < 8; s++) begin
			r = rnd();
			if (s > 0 && s < 4)
				notes.push_back({strb_tab[s[1:0]], 6'h15, 11'h0, r[15:0],
					r[19:16], 1'b0});
			bcs_host_inst.send(s[2:0], r[19:16], r[15:0]);
			if (s == 0)
				check("self", o_self_config, r[15:0]);
		end
		check("frames left", notes.size(), 41'h0);
		finish_test();
	end

	// Run needs about 2200 clocks; cut off well beyond that
	initial begin
		#(20000 * 100);
		errors++;
		finish_test();
	end
endmodule // tb_board_control_serial_steering
